// >>> design/rhsp_device.sv
// Device end: serial port, three config registers, buffer stream path.
// Assumes link pins are asynchronous to clock_i and sampled twice.
// What this block does
// - Select high registers, select low buffer
// - Host keeps select high whole transaction
// - Select low resets; new transaction after high
// - One register per transaction, no increment
// - Bytes move most significant bit first
// - Sample rising edge, shift falling edge
// - First byte: direction bit, 7-bit address
// - Second byte is data; two bytes
// - Host waits 20 us before first bit
// - Select low: read in receive, write transmit
// - Host holds select low during buffer transfer
// - User registers 0x00 to 0x02, reset defaults
// - Register 0 bit 7 is direction
// - Register 0 bits 6..0 channel number
// - Register 1 bits 4..3 transmit power
// - Register 1 bits 2..0 crystal select
// - Host writes zeros to reserved bits
// - Register 2 bit 6 burst mode
// - Register 2 bit 5 air rate
// - Register 2 bit 4 scrambling enable
// - Register 2 bit 3 check code enable
// - Register 2 bit 0 failed-check policy
// - Passing packet raises interrupt; failure none only with check code enabled
`timescale 1ns/100ps
module rhsp_device
    import rhsp_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Link
    rhsp_if.dev_mp link,
    // Configuration outputs
    output logic transmit_dir_o,
    output logic [6:0] channel_number_o,
    output logic [1:0] tx_power_level_o,
    output logic [2:0] crystal_select_o,
    output logic burst_mode_o,
    output logic air_rate_select_o,
    output logic scramble_en_o,
    output logic check_en_o,
    output logic keep_on_fail_o,
    // Packet buffer stream
    input wire logic [7:0] rx_byte_i,
    output logic rx_byte_take_o,
    output logic [7:0] tx_byte_o,
    output logic tx_byte_valid_o,
    // Received packet check result
    input wire logic pkt_done_i,
    input wire logic pkt_ok_i,
    output logic pkt_irq_o,
    output logic buf_clear_o
);
    typedef struct packed {
        logic [1:0] sclk_s;
        logic [1:0] sel_s;
        logic [1:0] dat_s;
        logic sclk_d;
        logic armed;
        logic [4:0] bitcnt;
        logic [7:0] shin;
        logic [7:0] shout;
        logic is_write;
        logic [6:0] addr;
        logic out_bit;
        logic out_oe;
        logic [7:0] r0;
        logic [7:0] r1;
        logic [7:0] r2;
        logic rx_take;
        logic [7:0] tx_byte;
        logic tx_valid;
        logic irq;
        logic clr;
    } rhsp_dev_t;

    rhsp_dev_t state_reg;
    rhsp_dev_t state_next;

    function automatic logic [7:0] read_reg(input logic [6:0] a, input rhsp_dev_t s);
        case (a)
            REG_DIR_CHAN: read_reg = s.r0;
            REG_PWR_XTAL: read_reg = s.r1;
            REG_DATA_FUNC: read_reg = s.r2;
            default: read_reg = 8'h00;
        endcase
    endfunction

    logic rise;
    logic fall;
    logic sel;
    logic din;
    assign rise = state_reg.sclk_s[1] & ~state_reg.sclk_d;
    assign fall = ~state_reg.sclk_s[1] & state_reg.sclk_d;
    assign sel = state_reg.sel_s[1];
    assign din = state_reg.dat_s[1];

    always_comb begin
        state_next = state_reg;
        state_next.sclk_s = {state_reg.sclk_s[0], link.sclk};
        state_next.sel_s = {state_reg.sel_s[0], link.select};
        state_next.dat_s = {state_reg.dat_s[0], link.data_line};
        state_next.sclk_d = state_reg.sclk_s[1];
        state_next.rx_take = 1'b0;
        state_next.tx_valid = 1'b0;
        state_next.irq = 1'b0;
        state_next.clr = 1'b0;
        if (!sel) begin
            // Select low resets register framing
            state_next.armed = 1'b1;
            state_next.out_oe = 1'b0;
            if (!state_reg.armed) begin
                state_next.bitcnt = 5'h00;
            end
            if (state_reg.armed && state_reg.r2[BURST_BIT]) begin
                if (state_reg.r0[DIR_BIT]) begin
                    if (rise) begin
                        state_next.shin = {state_reg.shin[6:0], din};
                        state_next.bitcnt = state_reg.bitcnt + 5'h01;
                        if (state_reg.bitcnt == 5'h07) begin
                            state_next.tx_byte = {state_reg.shin[6:0], din};
                            state_next.tx_valid = 1'b1;
                            state_next.bitcnt = 5'h00;
                        end
                    end
                end else begin
                    state_next.out_oe = 1'b1;
                    if (fall) begin
                        if (state_reg.bitcnt == 5'h00) begin
                            state_next.shout = {rx_byte_i[6:0], 1'b0};
                            state_next.out_bit = rx_byte_i[7];
                            state_next.rx_take = 1'b1;
                        end else begin
                            state_next.shout = {state_reg.shout[6:0], 1'b0};
                            state_next.out_bit = state_reg.shout[7];
                        end
                        state_next.bitcnt = (state_reg.bitcnt == 5'h07) ? 5'h00
                            : state_reg.bitcnt + 5'h01;
                    end
                end
            end
        end else begin
            // Register transaction while select high
            state_next.armed = 1'b0;
            if (state_reg.armed) begin
                state_next.bitcnt = 5'h00;
                state_next.out_oe = 1'b0;
            end else if (rise && state_reg.bitcnt < 5'h08) begin
                state_next.shin = {state_reg.shin[6:0], din};
                state_next.bitcnt = state_reg.bitcnt + 5'h01;
                if (state_reg.bitcnt == 5'h07) begin
                    state_next.is_write = state_reg.shin[6];
                    state_next.addr = {state_reg.shin[5:0], din};
                    state_next.shout = read_reg({state_reg.shin[5:0], din}, state_reg);
                end
            end else if (rise && state_reg.bitcnt < 5'h10) begin
                state_next.bitcnt = state_reg.bitcnt + 5'h01;
                state_next.shin = {state_reg.shin[6:0], din};
                if (state_reg.bitcnt == 5'h0F && state_reg.is_write) begin
                    case (state_reg.addr)
                        REG_DIR_CHAN: state_next.r0 = {state_reg.shin[6:0], din};
                        REG_PWR_XTAL: state_next.r1 = {state_reg.shin[6:0], din}
                            & MASK_PWR_XTAL;
                        REG_DATA_FUNC: state_next.r2 = {state_reg.shin[6:0], din}
                            & MASK_DATA_FUNC;
                        default: state_next.r0 = state_reg.r0;
                    endcase
                end
            end else if (fall && !state_reg.is_write && state_reg.bitcnt >= 5'h08
                && state_reg.bitcnt < 5'h10) begin
                state_next.out_oe = 1'b1;
                state_next.out_bit = state_reg.shout[7];
                state_next.shout = {state_reg.shout[6:0], 1'b0};
            end else if (fall && state_reg.bitcnt == 5'h10) begin
                state_next.out_oe = 1'b0;
            end
        end
        // Packet check result in burst receive
        if (pkt_done_i && state_reg.r2[BURST_BIT] && !state_reg.r0[DIR_BIT]) begin
            state_next.irq = pkt_ok_i | ~state_reg.r2[CHK_BIT];
            state_next.clr = ~pkt_ok_i & state_reg.r2[CHK_BIT]
                & ~state_reg.r2[KEEP_BIT];
        end
        if (reset_i) begin
            state_next = '0;
            state_next.armed = 1'b1;
            state_next.r0 = RST_DIR_CHAN;
            state_next.r1 = RST_PWR_XTAL;
            state_next.r2 = RST_DATA_FUNC;
        end
    end

    always_ff @(posedge clock_i) begin
        state_reg <= state_next;
    end

    assign link.data_dev = state_reg.out_bit;
    assign link.data_dev_oe = state_reg.out_oe;
    assign transmit_dir_o = state_reg.r0[DIR_BIT];
    assign channel_number_o = state_reg.r0[CHAN_MSB:0];
    assign tx_power_level_o = state_reg.r1[PWR_MSB:PWR_LSB];
    assign crystal_select_o = state_reg.r1[XTAL_MSB:0];
    assign burst_mode_o = state_reg.r2[BURST_BIT];
    assign air_rate_select_o = state_reg.r2[RATE_BIT];
    assign scramble_en_o = state_reg.r2[SCR_BIT] & state_reg.r2[BURST_BIT];
    assign check_en_o = state_reg.r2[CHK_BIT] & state_reg.r2[BURST_BIT];
    assign keep_on_fail_o = state_reg.r2[KEEP_BIT];
    assign rx_byte_take_o = state_reg.rx_take;
    assign tx_byte_o = state_reg.tx_byte;
    assign tx_byte_valid_o = state_reg.tx_valid;
    assign pkt_irq_o = state_reg.irq;
    assign buf_clear_o = state_reg.clr;
endmodule

// >>> design/rhsp_host.sv
// Host end: frames register reads and writes on the serial link.
// Assumes the device end answers on the same interface.
`timescale 1ns/100ps
module rhsp_host
    import rhsp_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Command port
    input wire logic [1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // Link
    rhsp_if.host_mp link
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b011,
        ST_END = 3'b100
    } rhsp_host_st_t;

    typedef struct packed {
        rhsp_host_st_t st;
        logic [15:0] wait_cnt;
        logic [4:0] bitcnt;
        logic [15:0] shout;
        logic [7:0] rxd;
        logic is_write;
        logic busy;
        logic sclk;
        logic sel;
        logic dout;
        logic doe;
        logic [1:0] din_s;
        logic [15:0] rdata;
    } rhsp_host_s_t;

    rhsp_host_s_t s_reg;
    rhsp_host_s_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.din_s = {s_reg.din_s[0], link.data_line};
        s_next.rdata = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                2'h0: s_next.rdata = {15'h0000, s_reg.busy};
                2'h1: s_next.rdata = {8'h00, s_reg.rxd};
                default: s_next.rdata = 16'h0000;
            endcase
        end
        case (s_reg.st)
            ST_IDLE: begin
                s_next.sel = 1'b0;
                s_next.sclk = 1'b0;
                s_next.doe = 1'b0;
                if (wr_i && addr_i == 2'h0 && !s_reg.busy) begin
                    s_next.shout = wdata_i;
                    s_next.is_write = wdata_i[WRITE_FLAG_BIT + 8];
                    s_next.busy = 1'b1;
                    s_next.sel = 1'b1;
                    s_next.wait_cnt = 16'(SEL_SETUP_CYC);
                    s_next.bitcnt = 5'h0;
                    s_next.st = ST_SETUP;
                end
            end
            ST_SETUP: begin
                s_next.wait_cnt = s_reg.wait_cnt - 16'h1;
                if (s_reg.wait_cnt == 16'h0) begin
                    s_next.doe = 1'b1;
                    s_next.dout = s_reg.shout[15];
                    s_next.wait_cnt = 16'(LINK_HALF_CYC);
                    s_next.st = ST_LOW;
                end
            end
            ST_LOW: begin
                s_next.wait_cnt = s_reg.wait_cnt - 16'h1;
                if (s_reg.wait_cnt == 16'h0) begin
                    s_next.sclk = 1'b1;
                    s_next.wait_cnt = 16'(LINK_HALF_CYC);
                    s_next.st = ST_HIGH;
                end
            end
            ST_HIGH: begin
                s_next.wait_cnt = s_reg.wait_cnt - 16'h1;
                if (s_reg.wait_cnt == 16'h0) begin
                    s_next.sclk = 1'b0;
                    s_next.bitcnt = s_reg.bitcnt + 5'h1;
                    s_next.shout = {s_reg.shout[14:0], 1'b0};
                    if (s_reg.bitcnt >= 5'h8) begin
                        s_next.rxd = {s_reg.rxd[6:0], s_reg.din_s[1]};
                    end
                    s_next.dout = s_reg.shout[14];
                    s_next.doe = s_reg.is_write || s_reg.bitcnt < 5'h7;
                    s_next.wait_cnt = 16'(LINK_HALF_CYC);
                    s_next.st = (s_reg.bitcnt == 5'hF) ? ST_END : ST_LOW;
                end
            end
            ST_END: begin
                s_next.doe = 1'b0;
                s_next.wait_cnt = s_reg.wait_cnt - 16'h1;
                if (s_reg.wait_cnt == 16'h0) begin
                    s_next.sel = 1'b0;
                    s_next.busy = 1'b0;
                    s_next.st = ST_IDLE;
                end
            end
            default: s_next.st = ST_IDLE;
        endcase
        if (reset_i) begin
            s_next = '0;
            s_next.st = ST_IDLE;
        end
    end

    always_ff @(posedge clock_i) begin
        s_reg <= s_next;
    end

    assign rdata_o = s_reg.rdata;
    assign link.sclk = s_reg.sclk;
    assign link.select = s_reg.sel;
    assign link.data_host = s_reg.dout;
    assign link.data_host_oe = s_reg.doe;
endmodule

// >>> design/rhsp_if.sv
// Interface: serial link between host and radio device.
// Assumes the bench resolves the data wire from the two enables.
`timescale 1ns/100ps
interface rhsp_if;
    logic sclk;
    logic select;
    logic data_host;
    logic data_host_oe;
    logic data_dev;
    logic data_dev_oe;
    logic data_line;
    modport dev_mp(input sclk, input select, input data_line,
        output data_dev, output data_dev_oe);
    modport host_mp(output sclk, output select, output data_host, output data_host_oe,
        input data_line);
endinterface

// >>> design/rhsp_pkg.sv
// Package: shared constants of the radio host serial port.
// Assumes both ends run on one 40 MHz system clock.
package rhsp_pkg;
    localparam int CLK_MHZ = 40;
    localparam int SEL_SETUP_US = 20;
    localparam int SEL_SETUP_CYC = SEL_SETUP_US * CLK_MHZ;
    localparam int LINK_HALF_CYC = 4;
    localparam logic [6:0] REG_DIR_CHAN = 7'h00;
    localparam logic [6:0] REG_PWR_XTAL = 7'h01;
    localparam logic [6:0] REG_DATA_FUNC = 7'h02;
    localparam logic [6:0] REG_LAST_USER = 7'h18;
    localparam logic [7:0] RST_DIR_CHAN = 8'h28;
    localparam logic [7:0] RST_PWR_XTAL = 8'h03;
    localparam logic [7:0] RST_DATA_FUNC = 8'h78;
    localparam int DIR_BIT = 7;
    localparam int CHAN_MSB = 6;
    localparam int PWR_MSB = 4;
    localparam int PWR_LSB = 3;
    localparam int XTAL_MSB = 2;
    localparam int BURST_BIT = 6;
    localparam int RATE_BIT = 5;
    localparam int SCR_BIT = 4;
    localparam int CHK_BIT = 3;
    localparam int KEEP_BIT = 0;
    localparam logic [7:0] MASK_PWR_XTAL = 8'h1F;
    localparam logic [7:0] MASK_DATA_FUNC = 8'h79;
    localparam int WRITE_FLAG_BIT = 7;
endpackage

// >>> tb/rhsp_checker.sv
// Checker: timing and turnaround of the host-to-device serial link.
// Assumes all link signals are driven from clock_i registers.
`timescale 1ns/100ps
module rhsp_checker
    import rhsp_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Link signals
    input wire logic sclk,
    input wire logic select,
    input wire logic data_host,
    input wire logic data_host_oe,
    input wire logic data_dev,
    input wire logic data_dev_oe,
    input wire logic data_line
);
    logic [11:0] sel_cnt;
    logic [4:0] bit_cnt;
    logic wr_flag;
    logic sclk_q;
    logic sel_q;

    // Time since select rose, bits seen in the frame, direction bit
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sel_cnt <= 12'h000;
            bit_cnt <= 5'h00;
            wr_flag <= 1'b0;
            sclk_q <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
            sel_q <= select;
            sel_cnt <= !select ? 12'h000 : (sel_cnt == 12'hFFF ? sel_cnt : sel_cnt + 12'h001);
            if (select && !sel_q) begin
                bit_cnt <= 5'h00;
            end else if (select && sclk && !sclk_q && bit_cnt != 5'h1F) begin
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == 5'h00) begin
                    wr_flag <= data_line;
                end
            end
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    sequence hi_phase;
        sclk [*4];
    endsequence
    sequence lo_phase;
        !sclk [*4];
    endsequence

    a_idle_clock_low: assert property (!select |-> !sclk)
        else $error("link clock moved outside a frame");
    a_setup_wait: assert property ($rose(sclk) |-> int'(sel_cnt) >= SEL_SETUP_CYC)
        else $error("first bit too soon after select");
    a_high_phase: assert property ($rose(sclk) |-> hi_phase)
        else $error("link clock high phase too short");
    a_low_phase: assert property ($fell(sclk) && select |-> lo_phase)
        else $error("link clock low phase too short");
    a_sample_stable: assert property (sclk && $past(sclk) |-> $stable(data_line))
        else $error("data moved while link clock high");
    a_no_clash: assert property (select |-> !(data_host_oe && data_dev_oe))
        else $error("both ends drive the data wire");
    a_read_turn: assert property ($rose(sclk) && select && bit_cnt >= 5'h08 && !wr_flag
        |-> data_dev_oe && !data_host_oe && data_line == data_dev)
        else $error("device not driving read data");
    a_host_drives: assert property ($rose(sclk) && select && (bit_cnt < 5'h08 || wr_flag)
        |-> data_host_oe && !data_dev_oe && data_line == data_host)
        else $error("host not driving its bits");
    a_frame_len: assert property ($fell(select) |-> bit_cnt == 5'h10)
        else $error("frame is not sixteen bits");
    a_dev_quiet: assert property ($rose(select) |-> ##3 !data_dev_oe)
        else $error("device still drives after select rose");
endmodule

// >>> tb/tb.sv
// Testbench: host and device ends on one link, a second device fed by
// a bench driver that breaks framing rules. Assumes a pull-up on data.
`timescale 1ns/100ps
module tb;
    import rhsp_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic pkt_done = 1'b0;
    logic pkt_ok = 1'b0;
    logic irq;
    logic clr;
    wire [17:0] cfg;
    wire [12:0] cfg2;
    logic [7:0] txb;
    logic txv;
    logic [7:0] txb_seen = 8'h00;
    logic [15:0] shreg = 16'h0000;
    logic [15:0] wire_word = 16'h0000;
    logic sclk_d = 1'b0;
    logic sel_d = 1'b0;
    logic [7:0] model [3];
    int bad_count = 0;
    int samples_checked = 0;

    rhsp_if link ();
    rhsp_if link2 ();
    assign link.data_line = link.data_dev_oe ? link.data_dev :
        link.data_host_oe ? link.data_host : 1'b1;
    assign link2.data_line = link2.data_dev_oe ? link2.data_dev :
        link2.data_host_oe ? link2.data_host : 1'b1;

    rhsp_host rhsp_host_inst (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link(link.host_mp));
    rhsp_device rhsp_device_inst (.clock_i(clock_i), .reset_i(reset_i), .link(link.dev_mp),
        .transmit_dir_o(cfg[17]), .channel_number_o(cfg[16:10]), .tx_power_level_o(cfg[9:8]),
        .crystal_select_o(cfg[7:5]), .burst_mode_o(cfg[4]), .air_rate_select_o(cfg[3]),
        .scramble_en_o(cfg[2]), .check_en_o(cfg[1]), .keep_on_fail_o(cfg[0]),
        .rx_byte_i(8'h00), .rx_byte_take_o(), .tx_byte_o(), .tx_byte_valid_o(),
        .pkt_done_i(pkt_done), .pkt_ok_i(pkt_ok), .pkt_irq_o(irq), .buf_clear_o(clr));
    rhsp_device rhsp_device_fault_inst (.clock_i(clock_i), .reset_i(reset_i),
        .link(link2.dev_mp), .transmit_dir_o(cfg2[12]), .channel_number_o(cfg2[11:5]),
        .tx_power_level_o(cfg2[4:3]), .crystal_select_o(cfg2[2:0]), .burst_mode_o(),
        .air_rate_select_o(), .scramble_en_o(), .check_en_o(), .keep_on_fail_o(),
        .rx_byte_i(8'h00), .rx_byte_take_o(), .tx_byte_o(txb), .tx_byte_valid_o(txv),
        .pkt_done_i(pkt_done), .pkt_ok_i(pkt_ok), .pkt_irq_o(), .buf_clear_o());
    rhsp_checker rhsp_checker_inst (.clock_i(clock_i), .reset_i(reset_i), .sclk(link.sclk),
        .select(link.select), .data_host(link.data_host), .data_host_oe(link.data_host_oe),
        .data_dev(link.data_dev), .data_dev_oe(link.data_dev_oe), .data_line(link.data_line));

    initial begin
        forever #12.5 clock_i = ~clock_i;
    end

    // Captures the wire bits of each frame and buffer bytes
    always @(posedge clock_i) begin
        sclk_d <= link.sclk;
        sel_d <= link.select;
        if (link.select && !sel_d) begin
            shreg <= 16'h0000;
        end else if (link.select && link.sclk && !sclk_d) begin
            shreg <= {shreg[14:0], link.data_line};
        end
        if (!link.select && sel_d) begin
            wire_word <= shreg;
        end
        if (txv === 1'b1) begin
            txb_seen <= txb;
        end
    end

    task automatic check_word(input string what, input logic [17:0] s, input logic [17:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmd(input logic w, input logic [1:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clock_i);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 q = rdata;
    endtask

    task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
        output logic [7:0] q);
        logic [15:0] r;
        cmd(1'b1, 2'h0, {w, a, d}, r);
        r = 16'h0001;
        while (r[0] !== 1'b0) begin
            cmd(1'b0, 2'h0, 16'h0000, r);
        end
        cmd(1'b0, 2'h1, 16'h0000, r);
        q = r[7:0];
    endtask

    function automatic logic [17:0] cfg_exp();
        return {model[0], model[1][4:0], model[2][6:5], model[2][4] & model[2][6],
            model[2][3] & model[2][6], model[2][0]};
    endfunction

    task automatic check_reg(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        xfer(1'b0, a, 8'h00, q);
        check_word("readback", {10'h000, q}, {10'h000, e});
        check_word("wire read", {2'b00, wire_word}, {3'b000, a, e});
    endtask

    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
        if (a < 7'h03) begin
            model[a[1:0]] = d;
        end
        check_word("wire write", {2'b00, wire_word}, {3'b001, a, d});
        check_word("config", cfg, cfg_exp());
        check_reg(a, a < 7'h03 ? d : 8'h00);
    endtask

    task automatic t_defaults();
        model = '{8'h28, 8'h03, 8'h78};
        check_word("reset config", cfg, cfg_exp());
        for (int i = 0; i < 3; i++) begin
            check_reg(7'(i), model[i]);
        end
    endtask

    task automatic t_fields();
        logic [7:0] modes [3] = '{8'h18, 8'h79, 8'h61};
        wr_reg(7'h00, 8'h01);
        wr_reg(7'h00, 8'hFF);
        for (int i = 0; i < 5; i++) begin
            wr_reg(7'h01, {3'b000, 2'(i), 3'(i)});
        end
        foreach (modes[i]) begin
            wr_reg(7'h02, modes[i]);
        end
        wr_reg(7'h7F, 8'h5A);
    endtask

    task automatic pkt(input logic ok, input logic ei, input logic ec);
        logic si;
        logic sc;
        si = 1'b0;
        sc = 1'b0;
        @(posedge clock_i);
        pkt_done <= 1'b1;
        pkt_ok <= ok;
        @(posedge clock_i);
        pkt_done <= 1'b0;
        repeat (5) begin
            #1;
            si = si | irq;
            sc = sc | clr;
            @(posedge clock_i);
        end
        check_word("irq", {17'h00000, si}, {17'h00000, ei});
        check_word("clear", {17'h00000, sc}, {17'h00000, ec});
    endtask

    task automatic t_packet();
        wr_reg(7'h00, 8'h28);
        wr_reg(7'h02, 8'h49);
        pkt(1'b0, 1'b0, 1'b0);
        pkt(1'b1, 1'b1, 1'b0);
        wr_reg(7'h02, 8'h48);
        pkt(1'b0, 1'b0, 1'b1);
        wr_reg(7'h02, 8'h40);
        pkt(1'b0, 1'b1, 1'b0);
    endtask

    task automatic drive2(input logic sel, input int n, input logic [31:0] b);
        @(posedge clock_i);
        link2.select <= sel;
        link2.data_host_oe <= 1'b1;
        repeat (SEL_SETUP_CYC + 4) @(posedge clock_i);
        for (int i = 0; i < n; i++) begin
            link2.data_host <= b[31 - i];
            repeat (5) @(posedge clock_i);
            link2.sclk <= 1'b1;
            repeat (5) @(posedge clock_i);
            link2.sclk <= 1'b0;
        end
        repeat (5) @(posedge clock_i);
        link2.select <= 1'b0;
        link2.data_host_oe <= 1'b0;
        repeat (10) @(posedge clock_i);
    endtask

    task automatic t_faults();
        drive2(1'b1, 32, 32'h8055_810C);
        check_word("no increment", {5'h00, cfg2}, {5'h00, 8'h55, 5'h03});
        drive2(1'b1, 12, 32'h8011_0000);
        check_word("short frame", {5'h00, cfg2}, {5'h00, 8'h55, 5'h03});
        drive2(1'b1, 16, 32'h810C_0000);
        check_word("new frame", {5'h00, cfg2}, {5'h00, 8'h55, 5'h0C});
        drive2(1'b1, 16, 32'h8240_0000);
        drive2(1'b1, 16, 32'h80D5_0000);
        drive2(1'b0, 8, 32'hA500_0000);
        check_word("buffer byte", {10'h000, txb_seen}, {10'h000, 8'hA5});
        check_word("config kept", {5'h00, cfg2}, {5'h00, 8'hD5, 5'h0C});
    endtask

    initial begin
        link2.sclk = 1'b0;
        link2.select = 1'b0;
        link2.data_host = 1'b0;
        link2.data_host_oe = 1'b0;
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        t_defaults();
        t_fields();
        t_packet();
        t_faults();
        summarize();
    end

    // About 38000 cycles expected; ceiling leaves ample margin
    initial begin
        repeat (60000) @(posedge clock_i);
        bad_count++;
        summarize();
    end
endmodule
